/* File: rtl/tmsa_params.svh */
`ifndef TMSA_PARAMS_SVH
`define TMSA_PARAMS_SVH
`define TMSA_OP_UNLOCK     8'hAC
`define TMSA_OP_LOCK       8'h78
`define TMSA_OP_ERASE      8'h0E
`define TMSA_OP_PROGRAM    8'h8E
`define TMSA_OP_FETCH      8'h4E
`define TMSA_OP_STATUS     8'h4A
`define TMSA_OP_BITS       8
`define TMSA_DUMMY_BITS    24
`define TMSA_FETCH_START   11
`define TMSA_DATA_START    32
`define TMSA_DONE_CLKS     3
`define TMSA_ERASE_CYC     16'h0400
`define TMSA_PROG_CYC      16'h0100
`define TMSA_FETCH_CYC     16'h0080
`endif

/* File: rtl/tmsa_pkg.sv */
package tmsa_pkg;
    typedef enum logic [2:0] {TMSA_IDLE, TMSA_ERASE, TMSA_PROG, TMSA_FETCH} tmsa_eng_t;
    typedef struct packed {
        logic boot_done;
        logic fuse_busy;
        logic flash_busy;
        logic boundary_scan_test;
        logic spi_off;
    } tmsa_avail_t;
endpackage

/* File: rtl/tmsa_fifo.sv */
`timescale 1ns/1ps
module tmsa_fifo
    import tmsa_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
)(
    input  wire logic             clock,   // Core clock
    input  wire logic             rst_n,   // Sync reset
    input  wire logic             in_valid,// Write request
    output logic                  in_ready,// Space free
    input  wire logic [WIDTH-1:0] in_data, // Write word
    output logic                  out_valid,// Word present
    input  wire logic             out_ready,// Read accept
    output logic      [WIDTH-1:0] out_data // Head word
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr;
        logic [AW:0] rd;
    } tmsa_fst_t;
    tmsa_fst_t s_q;
    tmsa_fst_t s_d;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic push;
    logic pop;
    assign in_ready  = (s_q.wr - s_q.rd) != (AW+1)'(DEPTH);
    assign out_valid = s_q.wr != s_q.rd;
    assign out_data  = mem_q[s_q.rd[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_comb
    begin
        s_d = s_q;
        if (push)
            s_d.wr = s_q.wr + 1'b1;
        if (pop)
            s_d.rd = s_q.rd + 1'b1;
    end
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
        if (push)
            mem_q[s_q.wr[AW-1:0]] <= in_data;
    end
endmodule

/* File: rtl/tmsa_core.sv */
`timescale 1ns/1ps
`include "tmsa_params.svh"
// Function
// - Refuse scratch memory access until boot has completed.
// - Interface resets on chip select rising edge.
// - Unavailable while configuration fuses are accessed or refreshed.
// - Unavailable while other flash cells are accessed.
// - Unavailable during boundary scan testing.
// - Serial interface disabled when persistent fuse set off.
// - Unlock must precede program, erase, status; lock ends it.
// - Unlock, lock, erase execute on the third clock after select rise, after 24 dummies.
// - Status bit cleared at action start, set on success.
// - Fetch starts third dummy clock after opcode.
module tmsa_core
    import tmsa_pkg::*;
#(
    parameter int PAGE_BITS = 32,
    parameter int ERASE_CYC = `TMSA_ERASE_CYC,
    parameter int PROG_CYC  = `TMSA_PROG_CYC,
    parameter int FETCH_CYC = `TMSA_FETCH_CYC
)(
    input  wire logic        clock,     // 250 MHz core clock
    input  wire logic        rst_n,     // Sync reset, active low
    input  wire logic        spi_clk,   // Link clock pin
    input  wire logic        spi_cs_n,  // Chip select pin
    input  wire logic        spi_si,    // Serial data in
    output logic             spi_so,    // Serial data out
    output logic             spi_so_oe, // Data out enable
    input  wire tmsa_avail_t avail,     // Device activity levels
    output logic             status_q,  // Status bit view
    output logic             unlock_q   // Unlock state view
);
    localparam int PW = $clog2(PAGE_BITS);
    localparam int CW = 8;

    typedef struct packed {
        logic [2:0]           clk_s;
        logic [2:0]           cs_s;
        logic [1:0]           si_s;
        tmsa_avail_t [1:0]    av_s;
        logic [CW-1:0]        cnt;
        logic [7:0]           op;
        logic                 unlock;
        logic                 status;
        tmsa_eng_t            eng;
        logic [15:0]          timer;
        logic [1:0]           post;
        logic [7:0]           pend;
        logic [PAGE_BITS-1:0] cells;
        logic [PAGE_BITS-1:0] buffer;
        logic [PW:0]          nbits;
        logic                 so;
        logic                 so_oe;
        logic                 st_cap;
    } tmsa_st_t;

    tmsa_st_t s_q;
    tmsa_st_t s_d;
    logic     rise;
    logic     fall;
    logic     cs_rise;
    logic     sel;
    logic     up;
    logic     f_valid;
    logic     f_ready;
    logic     f_bit;
    logic     f_out_valid;
    logic     f_pop;

    assign rise    = s_q.clk_s[1] && !s_q.clk_s[2];
    assign fall    = !s_q.clk_s[1] && s_q.clk_s[2];
    assign cs_rise = s_q.cs_s[1] && !s_q.cs_s[2];
    assign sel     = !s_q.cs_s[1];
    // Availability gate: boot done and no competing activity
    // boot, busy, off gates
    assign up      = s_q.av_s[1].boot_done && !s_q.av_s[1].fuse_busy && !s_q.av_s[1].flash_busy
                     && !s_q.av_s[1].boundary_scan_test && !s_q.av_s[1].spi_off;

    // ------------------------------------------------------------
    // Program data path
    // ------------------------------------------------------------
    // Incoming page bits queue here and drain into the buffer every core clock, busy engine or not
    tmsa_fifo #(.WIDTH(1), .DEPTH(16)) u_fifo (
        .clock     (clock),
        .rst_n     (rst_n),
        .in_valid  (f_valid),
        .in_ready  (f_ready),
        .in_data   (s_q.si_s[1]),
        .out_valid (f_out_valid),
        .out_ready (f_pop),
        .out_data  (f_bit)
    );
    assign f_valid = sel && rise && up && s_q.op == `TMSA_OP_PROGRAM && s_q.unlock
                     && s_q.cnt >= CW'(`TMSA_DATA_START) && f_ready;
    assign f_pop   = f_out_valid;

    always_comb
    begin
        s_d       = s_q;
        s_d.clk_s = {s_q.clk_s[1:0], spi_clk};
        s_d.cs_s  = {s_q.cs_s[1:0], spi_cs_n};
        s_d.si_s  = {s_q.si_s[0], spi_si};
        // Activity levels pass both stages before the gate combines them
        s_d.av_s  = {s_q.av_s[0], avail};
        if (f_pop && s_q.nbits <= (PW+1)'(PAGE_BITS - 1))
        begin
            s_d.buffer = {f_bit, s_q.buffer[PAGE_BITS-1:1]};
            s_d.nbits  = s_q.nbits + 1'b1;
        end
        if (cs_rise || !up)
        begin
            s_d.cnt   = '0;
            s_d.so_oe = 1'b0;
            if (cs_rise && up && s_q.cnt >= CW'(`TMSA_OP_BITS + `TMSA_DUMMY_BITS))
            begin
                s_d.pend = s_q.op;
                s_d.post = '0;
            end
        end
        else if (sel && rise)
        begin
            if (s_q.cnt != '1)
                s_d.cnt = s_q.cnt + 1'b1;
            if (s_q.cnt < CW'(`TMSA_OP_BITS))
            begin
                s_d.op    = {s_q.op[6:0], s_q.si_s[1]};
                s_d.nbits = '0;
            end
            // fetch begins on third dummy clock
            if (s_q.cnt == CW'(`TMSA_FETCH_START - 1) && s_q.op == `TMSA_OP_FETCH
                && s_q.eng == TMSA_IDLE)
            begin
                s_d.eng   = TMSA_FETCH;
                s_d.timer = 16'(FETCH_CYC);
            end
            if (s_q.cnt == CW'(`TMSA_OP_BITS - 1) && {s_q.op[6:0], s_q.si_s[1]} == `TMSA_OP_STATUS)
                s_d.st_cap = s_q.status;
        end
        else if (sel && fall && s_q.cnt >= CW'(`TMSA_DATA_START - 1))
        begin
            if (s_q.op == `TMSA_OP_FETCH)
            begin
                s_d.so_oe  = 1'b1;
                s_d.so     = s_q.buffer[0];
                s_d.buffer = {1'b0, s_q.buffer[PAGE_BITS-1:1]};
            end
            else if (s_q.op == `TMSA_OP_STATUS && s_q.unlock)
            begin
                s_d.so_oe  = 1'b1;
                s_d.so     = s_q.st_cap;
                s_d.st_cap = 1'b0;
            end
        end
        // three clocks after select rise complete the action
        if (s_q.pend != 8'h00 && !sel && rise)
        begin
            s_d.post = s_q.post + 1'b1;
            if (s_q.post == 2'(`TMSA_DONE_CLKS - 1))
            begin
                s_d.pend = 8'h00;
                unique case (s_q.pend)
                    `TMSA_OP_UNLOCK: s_d.unlock = 1'b1;
                    `TMSA_OP_LOCK:   s_d.unlock = 1'b0;
                    `TMSA_OP_ERASE,
                    `TMSA_OP_PROGRAM:
                    if (s_q.unlock && s_q.eng == TMSA_IDLE)
                    begin
                        s_d.status = 1'b0;
                        s_d.eng    = s_q.pend == `TMSA_OP_ERASE ? TMSA_ERASE : TMSA_PROG;
                        s_d.timer  = s_q.pend == `TMSA_OP_ERASE ? 16'(ERASE_CYC) : 16'(PROG_CYC);
                    end
                    default: ;
                endcase
            end
        end
        if (s_q.eng != TMSA_IDLE)
        begin
            s_d.timer = s_q.timer - 1'b1;
            if (s_q.timer == 16'h0001)
            begin
                s_d.eng = TMSA_IDLE;
                unique case (s_q.eng)
                    TMSA_ERASE: s_d.cells = '0;
                    TMSA_PROG:  s_d.cells = s_q.buffer;
                    TMSA_FETCH: s_d.buffer = s_q.cells;
                    default: ;
                endcase
                if (s_q.eng != TMSA_FETCH)
                    s_d.status = 1'b1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            s_q        <= '0;
            s_q.clk_s  <= '0;
            s_q.cs_s   <= 3'h7;
            s_q.status <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign spi_so    = s_q.so;
    assign spi_so_oe = s_q.so_oe;
    assign status_q  = s_q.status;
    assign unlock_q  = s_q.unlock;

    a_gate_no_drive: assert property (@(posedge clock) disable iff (!rst_n)
        !up |=> !spi_so_oe) else $error("output driven while unavailable");
    a_status_clear: assert property (@(posedge clock) disable iff (!rst_n)
        (s_q.eng == TMSA_IDLE ##1 (s_q.eng == TMSA_ERASE || s_q.eng == TMSA_PROG)) |-> !status_q)
        else $error("status not cleared at start");
    // status set when an erase or program finishes
    a_status_set: assert property (@(posedge clock) disable iff (!rst_n)
        ((s_q.eng == TMSA_ERASE || s_q.eng == TMSA_PROG) && s_q.timer == 16'h0001) |=> status_q)
        else $error("status not set at finish");
    a_cs_release: assert property (@(posedge clock) disable iff (!rst_n)
        cs_rise |=> !spi_so_oe && s_q.cnt == '0) else $error("select rise did not reset");
    a_locked_idle: assert property (@(posedge clock) disable iff (!rst_n)
        (!unlock_q && s_q.eng != TMSA_PROG) |=> s_q.eng != TMSA_PROG) else $error("program while locked");
    // fetch starts on third dummy clock
    a_fetch_start: assert property (@(posedge clock) disable iff (!rst_n)
        (sel && rise && up && s_q.cnt == CW'(`TMSA_FETCH_START - 1) && s_q.op == `TMSA_OP_FETCH
         && s_q.eng == TMSA_IDLE) |=> s_q.eng == TMSA_FETCH) else $error("fetch did not start");
endmodule

/* File: sim/tmsa_spi_host.sv */
`timescale 1ns/1ps
module tmsa_spi_host (
    input  wire logic clock,    // Core clock, paces the link
    output logic      spi_clk,  // Link clock, runs three more cycles after each frame
    output logic      spi_cs_n, // Chip select
    output logic      spi_si,   // Serial data to device
    input  wire logic spi_so,   // Serial data from device
    input  wire logic spi_so_oe // Device drive enable
);
    initial
    begin
        spi_clk  = 1'b0;
        spi_cs_n = 1'b1;
        spi_si   = 1'b0;
    end

    // Half of a 160 ns link period
    task automatic half();
        repeat (20) @(negedge clock);
    endtask

    task automatic cs_reset();
        spi_cs_n = 1'b0;
        half();
        spi_cs_n = 1'b1;
        half();
    endtask

    task automatic frame(input logic [7:0] op, input logic [31:0] dat, input int n, output logic [31:0] rd);
        rd = '0;
        spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            // Dummy bits toggle so a stale level is never mistaken for data
            spi_si = (i < 8) ? op[7-i] : (i >= 32) ? dat[i-32] : ~spi_si;
            half();
            // Device drives from the fall of clock 31; sample on the rise of clock 32
            if (i >= 31 && i < 63)
                rd[i-31] = spi_so_oe ? spi_so : 1'bx;
            spi_clk = 1'b1;
            half();
            spi_clk = 1'b0;
        end
        spi_cs_n = 1'b1;
        repeat (3)
        begin
            spi_si = ~spi_si;
            half();
            spi_clk = 1'b1;
            half();
            spi_clk = 1'b0;
        end
    endtask
endmodule

/* File: sim/tag_memory_spi_access_test.sv */
`timescale 1ns/1ps
`include "tmsa_params.svh"
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin fail_count++; $display("wrong value %s exp %h got %h", nm, e, g); end end
module tag_memory_spi_access_test
    import tmsa_pkg::*;
;
    logic        clock = 1'b0;
    logic        rst_n;
    logic        spi_clk;
    logic        spi_cs_n;
    logic        spi_si;
    logic        spi_so;
    logic        spi_so_oe;
    logic        status_q;
    logic        unlock_q;
    tmsa_avail_t avail;
    logic [31:0] rd;
    int          fail_count = 0;
    int          compares = 0;
    int          cycles = 0;

    // ----------------------------------------
    // Clock, device and link master
    // ----------------------------------------
    initial
    begin
        forever #2 clock = ~clock;
    end

    // Erase and program times lengthened so a status frame lands inside an action
    tmsa_core #(.ERASE_CYC(4000), .PROG_CYC(3000)) uut (
        .clock     (clock),
        .rst_n     (rst_n),
        .spi_clk   (spi_clk),
        .spi_cs_n  (spi_cs_n),
        .spi_si    (spi_si),
        .spi_so    (spi_so),
        .spi_so_oe (spi_so_oe),
        .avail     (avail),
        .status_q  (status_q),
        .unlock_q  (unlock_q)
    );

    tmsa_spi_host host (
        .clock     (clock),
        .spi_clk   (spi_clk),
        .spi_cs_n  (spi_cs_n),
        .spi_si    (spi_si),
        .spi_so    (spi_so),
        .spi_so_oe (spi_so_oe)
    );

    // ----------------------------------------
    // Closing and hang guard
    // ----------------------------------------
    task automatic complete_run();
        if (fail_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            fail_count++;
            complete_run();
        end
    end

    task automatic poll();
        for (int j = 0; j < 6 && rd[0] !== 1'b1; j++)
            host.frame(`TMSA_OP_STATUS, 32'h0, 40, rd);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        rst_n = 1'b0;
        avail = '0;
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        // settle before first command, scaled down
        repeat (10) @(negedge clock);
        host.frame(`TMSA_OP_UNLOCK, 32'h0, 32, rd);
        `CHK("unlock_q", 1'b0, unlock_q)
        avail.boot_done = 1'b1;
        repeat (10) @(negedge clock);
        host.cs_reset();
        host.frame(`TMSA_OP_UNLOCK, 32'h0, 32, rd);
        `CHK("unlock_q", 1'b1, unlock_q)
        for (int k = 0; k < 4; k++)
        begin
            avail = tmsa_avail_t'(5'h10 | (5'h08 >> k));
            host.frame(`TMSA_OP_LOCK, 32'h0, 32, rd);
            `CHK("unlock_q", 1'b1, unlock_q)
        end
        avail = tmsa_avail_t'(5'h10);
        repeat (10) @(negedge clock);
        host.frame(`TMSA_OP_LOCK, 32'h0, 32, rd);
        `CHK("unlock_q", 1'b0, unlock_q)
        host.frame(`TMSA_OP_ERASE, 32'h0, 32, rd);
        `CHK("status_q", 1'b1, status_q)
        host.frame(`TMSA_OP_UNLOCK, 32'h0, 32, rd);
        host.frame(`TMSA_OP_ERASE, 32'h0, 32, rd);
        `CHK("status_q", 1'b0, status_q)
        host.frame(`TMSA_OP_STATUS, 32'h0, 40, rd);
        `CHK("status bit", 1'b0, rd[0])
        poll();
        `CHK("status bit", 1'b1, rd[0])
        host.frame(`TMSA_OP_PROGRAM, 32'hA5C30F96, 64, rd);
        `CHK("status_q", 1'b0, status_q)
        poll();
        `CHK("status bit", 1'b1, rd[0])
        host.frame(`TMSA_OP_FETCH, 32'h0, 64, rd);
        `CHK("fetch data", 32'hA5C30F96, rd)
        complete_run();
    end
endmodule
